// ==== logic/sdp_packer.v ====
`include "sdp_consts.vh"

module sdp_packer #(
    parameter CH = `SDP_CHANNELS,
    parameter MS_CYCLES = `SDP_MS_CYCLES,
    parameter DEPTH = `SDP_FIFO_DEPTH
) (
    input wire clk_sys,
    input wire reset,
    input wire dual_channel_mode,
    input wire cfg_apply,
    input wire [CH*`SDP_LEN_W-1:0] cfg_pkt_len,
    input wire [CH*`SDP_DATA_W-1:0] cfg_dlm1,
    input wire [CH*`SDP_DATA_W-1:0] cfg_dlm2,
    input wire [CH-1:0] cfg_match_one,
    input wire [CH*`SDP_POST_W-1:0] cfg_post,
    input wire [CH*`SDP_TO_W-1:0] cfg_force_ms,
    input wire [CH*`SDP_DATA_W-1:0] ser_data,
    input wire [CH-1:0] ser_valid,
    output wire [CH-1:0] ser_ready,
    output wire [CH*`SDP_DATA_W-1:0] net_data,
    output wire [CH-1:0] net_last,
    output wire [CH-1:0] net_valid,
    input wire [CH-1:0] net_ready,
    output wire [CH-1:0] chan_active
);

    // ----------------------------------------------------------------
    // settings load strobe
    // ----------------------------------------------------------------
    reg load_reg;

    // load once after restart and on every apply
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            load_reg <= 1'b1;
        end else begin
            load_reg <= cfg_apply;
        end
    end

    // ----------------------------------------------------------------
    // per channel packer
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1) begin : g_ch
            // active settings
            reg [`SDP_LEN_W-1:0] len_reg;
            reg [`SDP_DATA_W-1:0] d1_reg;
            reg [`SDP_DATA_W-1:0] d2_reg;
            reg one_reg;
            reg [`SDP_POST_W-1:0] post_reg;
            reg [`SDP_TO_W-1:0] fto_reg;
            reg en_reg;
            // frame state
            reg [`SDP_DATA_W-1:0] pend_reg;
            reg pv_reg;
            reg pl_reg;
            reg [`SDP_LEN_W-1:0] cnt_reg;
            reg [`SDP_POST_W-1:0] extra_reg;
            reg prev1_reg;
            reg rdy_reg;
            // idle timer
            reg [`SDP_PRE_W-1:0] pre_reg;
            reg [`SDP_TO_W-1:0] idle_reg;

            wire [`SDP_DATA_W-1:0] b = ser_data[i*`SDP_DATA_W +: `SDP_DATA_W];
            wire acc = ser_valid[i] & rdy_reg;
            wire [`SDP_LEN_W-1:0] ncnt = cnt_reg + `SDP_CNT_ONE;
            wire f_ready;
            wire f_room2;

            // ------------------------------------------------------------
            // delimiter matching
            // ------------------------------------------------------------
            wire d1_on = (d1_reg != `SDP_DLM_NONE);
            wire d2_on = (d2_reg != `SDP_DLM_NONE);
            wire dlm_en = d1_on | d2_on;
            wire hit1 = d1_on & (b == d1_reg);
            wire hit2 = d2_on & (b == d2_reg);
            // sequence only when both set and two-byte mode
            wire seq_mode = ~one_reg & d1_on & d2_on;
            wire dmatch = seq_mode ? (prev1_reg & hit2) : (hit1 | hit2);
            // extra bytes need the first delimiter
            wire [`SDP_POST_W-1:0] post_on = d1_on ? post_reg : `SDP_POST_NONE;
            wire waiting = (extra_reg != `SDP_POST_NONE);
            wire d_arm = dlm_en & ~waiting & dmatch & (post_on != `SDP_POST_NONE);
            wire d_close = dlm_en &
                (waiting ? (extra_reg == `SDP_POST_ONE) :
                 (dmatch & (post_on == `SDP_POST_NONE)));

            // ------------------------------------------------------------
            // closing conditions, all joined into one end mark
            // ------------------------------------------------------------
            wire len_close = (len_reg != `SDP_LEN_NONE) & (ncnt >= len_reg);
            wire full_close = (ncnt == `SDP_BUF_BYTES);
            wire pass_close = ~dlm_en & (len_reg == `SDP_LEN_NONE);
            wire close = len_close | full_close | pass_close | d_close;
            // timeout only with a byte held, so no empty frame
            wire fire_to = (fto_reg != `SDP_TO_OFF) & (idle_reg >= fto_reg) &
                pv_reg & ~pl_reg;
            wire flush = pv_reg & pl_reg & f_ready & ~acc;
            wire pl_nx = acc ? close : (flush ? 1'b0 : (fire_to | pl_reg));
            // the held byte leaves when replaced or when its frame ends
            wire push = pv_reg & (acc | (pl_reg & f_ready));
            wire ms_tick = (pre_reg == MS_CYCLES[`SDP_PRE_W-1:0] - {{(`SDP_PRE_W-1){1'b0}}, 1'b1});

            assign ser_ready[i] = rdy_reg;
            assign chan_active[i] = en_reg;

            // settings latch, separate per channel
            always @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    len_reg <= `SDP_LEN_NONE;
                    d1_reg <= `SDP_DLM_NONE;
                    d2_reg <= `SDP_DLM_NONE;
                    one_reg <= 1'b0;
                    post_reg <= `SDP_POST_NONE;
                    fto_reg <= `SDP_TO_OFF;
                    en_reg <= 1'b0;
                end else if (load_reg) begin
                    len_reg <= cfg_pkt_len[i*`SDP_LEN_W +: `SDP_LEN_W];
                    d1_reg <= cfg_dlm1[i*`SDP_DATA_W +: `SDP_DATA_W];
                    d2_reg <= cfg_dlm2[i*`SDP_DATA_W +: `SDP_DATA_W];
                    one_reg <= cfg_match_one[i];
                    post_reg <= cfg_post[i*`SDP_POST_W +: `SDP_POST_W];
                    fto_reg <= cfg_force_ms[i*`SDP_TO_W +: `SDP_TO_W];
                    en_reg <= (i == 0) | dual_channel_mode;
                end
            end

            // held byte, frame count and delimiter progress
            always @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    pend_reg <= {`SDP_DATA_W{1'b0}};
                    pv_reg <= 1'b0;
                    pl_reg <= 1'b0;
                    cnt_reg <= `SDP_LEN_NONE;
                    extra_reg <= `SDP_POST_NONE;
                    prev1_reg <= 1'b0;
                    rdy_reg <= 1'b0;
                end else if (load_reg) begin
                    // new settings start from an empty buffer
                    pv_reg <= 1'b0;
                    pl_reg <= 1'b0;
                    cnt_reg <= `SDP_LEN_NONE;
                    extra_reg <= `SDP_POST_NONE;
                    prev1_reg <= 1'b0;
                    rdy_reg <= 1'b0;
                end else begin
                    rdy_reg <= en_reg & f_room2 & ~pl_nx;
                    pl_reg <= pl_nx;
                    if (acc) begin
                        pend_reg <= b;
                        pv_reg <= 1'b1;
                        cnt_reg <= close ? `SDP_LEN_NONE : ncnt;
                        prev1_reg <= close ? 1'b0 : hit1;
                        if (close) begin
                            extra_reg <= `SDP_POST_NONE;
                        end else if (d_arm) begin
                            extra_reg <= post_on;
                        end else if (waiting) begin
                            extra_reg <= extra_reg - `SDP_POST_ONE;
                        end
                    end else if (flush) begin
                        pv_reg <= 1'b0;
                    end else if (fire_to) begin
                        cnt_reg <= `SDP_LEN_NONE;
                        extra_reg <= `SDP_POST_NONE;
                        prev1_reg <= 1'b0;
                    end
                end
            end

            // millisecond idle timer, restarted by each byte
            always @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    pre_reg <= {`SDP_PRE_W{1'b0}};
                    idle_reg <= `SDP_TO_OFF;
                end else if (acc | load_reg | ~pv_reg | pl_reg) begin
                    pre_reg <= {`SDP_PRE_W{1'b0}};
                    idle_reg <= `SDP_TO_OFF;
                end else if (ms_tick) begin
                    pre_reg <= {`SDP_PRE_W{1'b0}};
                    if (idle_reg != `SDP_TO_MAX) begin
                        idle_reg <= idle_reg + 16'h0001;
                    end
                end else begin
                    pre_reg <= pre_reg + {{(`SDP_PRE_W-1){1'b0}}, 1'b1};
                end
            end

            // ------------------------------------------------------------
            // output queue toward the network side
            // ------------------------------------------------------------
            sdp_fifo #(
                .WIDTH(`SDP_DATA_W + 1),
                .DEPTH(DEPTH),
                .AW(4)
            ) u_fifo (
                .clk_sys(clk_sys),
                .reset(reset),
                .in_data({pl_reg & ~acc, pend_reg}),
                .in_valid(push),
                .in_ready(f_ready),
                .in_room2(f_room2),
                .out_data({net_last[i], net_data[i*`SDP_DATA_W +: `SDP_DATA_W]}),
                .out_valid(net_valid[i]),
                .out_ready(net_ready[i])
            );
        end
    endgenerate

endmodule // sdp_packer

// ==== common/sdp_consts.vh ====
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SDP_DATA_W 8
`define SDP_LEN_W 11
`define SDP_TO_W 16
`define SDP_POST_W 2
`define SDP_PRE_W 15

// ----------------------------------------------------------------
// sizes and encodings
// ----------------------------------------------------------------
`define SDP_BUF_BYTES 11'h400
`define SDP_LEN_NONE 11'h000
`define SDP_CNT_ONE 11'h001
`define SDP_DLM_NONE 8'h00
`define SDP_TO_OFF 16'h0000
`define SDP_TO_MAX 16'hFFFF
`define SDP_POST_NONE 2'h0
`define SDP_POST_ONE 2'h1
`define SDP_POST_TWO 2'h2
`define SDP_FIFO_DEPTH 16
`define SDP_CHANNELS 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDP_MS_NS 1000000
`define SDP_CLK_NS 40
`define SDP_MS_CYCLES (`SDP_MS_NS / `SDP_CLK_NS)

`endif

// ==== logic/sdp_fifo.v ====
`include "sdp_consts.vh"

module sdp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = `SDP_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire reset,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire in_room2,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);

    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    reg [AW:0] cnt_reg;
    reg [WIDTH-1:0] od_reg;
    reg ov_reg;

    wire wr = in_valid & in_ready;
    wire ld = (cnt_reg != {(AW+1){1'b0}}) & (~ov_reg | out_ready);

    // full and near-full flags from the entry count
    assign in_ready = (cnt_reg < DEPTH[AW:0]);
    assign in_room2 = (cnt_reg <= (DEPTH[AW:0] - {{AW{1'b0}}, 1'b1} - {{AW{1'b0}}, 1'b1}));
    assign out_data = od_reg;
    assign out_valid = ov_reg;

    // write port, no reset needed on the array
    always @(posedge clk_sys) begin
        if (wr) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    // pointers, count and registered output stage
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            od_reg <= {WIDTH{1'b0}};
            ov_reg <= 1'b0;
        end else begin
            if (wr) begin
                wp_reg <= (wp_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
                    {AW{1'b0}} : wp_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (ld) begin
                od_reg <= mem_reg[rp_reg];
                rp_reg <= (rp_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
                    {AW{1'b0}} : rp_reg + {{(AW-1){1'b0}}, 1'b1};
                ov_reg <= 1'b1;
            end else if (out_ready) begin
                ov_reg <= 1'b0;
            end
            if (wr & ~ld) begin
                cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
            end else if (~wr & ld) begin
                cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // sdp_fifo

// ==== test/sdp_host_model.sv ====
module sdp_host_model (
    input wire clk_sys,
    input wire ser_ready,
    output logic [7:0] ser_data,
    output logic ser_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // line quiet from time zero
    initial begin
        ser_valid = 1'b0;
        ser_data = 8'h00;
    end

    // offer a byte, hold it until the edge that takes it
    task automatic send(input logic [7:0] b);
        ser_data = b;
        ser_valid = 1'b1;
        while (ser_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask

    // released line shows the inverse of the last byte
    task automatic idle(input int n);
        ser_valid = 1'b0;
        ser_data = ~ser_data;
        repeat (n) @(negedge clk_sys);
    endtask
endmodule // sdp_host_model

// ==== test/sdp_packer_monitor.sv ====
`include "sdp_consts.vh"

module sdp_packer_monitor #(
    parameter CH = 2
) (
    input wire clk_sys,
    input wire reset,
    input wire cfg_apply,
    input wire [CH*`SDP_LEN_W-1:0] cfg_pkt_len,
    input wire [CH*`SDP_DATA_W-1:0] cfg_dlm1,
    input wire [CH*`SDP_DATA_W-1:0] cfg_dlm2,
    input wire [CH-1:0] ser_valid,
    input wire [CH-1:0] ser_ready,
    input wire [CH*`SDP_DATA_W-1:0] net_data,
    input wire [CH-1:0] net_last,
    input wire [CH-1:0] net_valid,
    input wire [CH-1:0] net_ready,
    input wire [CH-1:0] chan_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // channel 0 sequences
    // ----------------------------------------
    sequence s_taken;
        ser_valid[0] && ser_ready[0];
    endsequence
    sequence s_bare;
        cfg_pkt_len[10:0] == 11'h000 && cfg_dlm1[7:0] == 8'h00 && cfg_dlm2[7:0] == 8'h00;
    endsequence

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_net_hold:
    assert property (net_valid[0] && !net_ready[0] |=> net_valid[0]
        && $stable(net_data[7:0]) && $stable(net_last[0])) else $error("net word changed");
    chk_load_gap:
    assert property (cfg_apply |-> ##[1:2] !ser_ready[0]) else $error("no ready gap on load");
    chk_load_resume:
    assert property (cfg_apply |-> ##[2:5] ser_ready[0]) else $error("ready not back");
    chk_chan_off:
    assert property (!chan_active[1] |-> !ser_ready[1]) else $error("idle channel ready");
    chk_bare_last:
    assert property (s_bare ##0 net_valid[0] |-> net_last[0]) else $error("bare byte not last");
    chk_bare_out:
    assert property (s_bare ##0 s_taken |-> ##[1:3] net_valid[0]) else $error("byte not sent");
    chk_len_one:
    assert property (cfg_pkt_len[21:11] == 11'h001 && net_valid[1] |-> net_last[1])
        else $error("length one not last");
    chk_reset_quiet:
    assert property ($fell(reset) |-> !ser_ready[0] && !net_valid[0]) else $error("early ready");
endmodule // sdp_packer_monitor

bind sdp_packer sdp_packer_monitor #(.CH(CH)) i_mon (.clk_sys(clk_sys), .reset(reset),
    .cfg_apply(cfg_apply), .cfg_pkt_len(cfg_pkt_len), .cfg_dlm1(cfg_dlm1),
    .cfg_dlm2(cfg_dlm2), .ser_valid(ser_valid), .ser_ready(ser_ready), .net_data(net_data),
    .net_last(net_last), .net_valid(net_valid), .net_ready(net_ready),
    .chan_active(chan_active));

// ==== test/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 8;
    logic clk_sys, reset, dual_channel_mode, cfg_apply, stall;
    logic [21:0] cfg_pkt_len;
    logic [15:0] cfg_dlm1, cfg_dlm2, ser_data, net_data;
    logic [1:0] cfg_match_one, ser_valid, ser_ready, net_last, net_valid, net_ready, chan_active;
    logic [3:0] cfg_post;
    logic [31:0] cfg_force_ms;
    logic [8:0] exp_q[2][$];
    logic [10:0] cnt[2];
    logic [1:0] pend[2];
    logic prev1[2];
    int failures, checks_done;
    int rlen;
    logic [8:0] got;

    sdp_packer #(.CH(2), .MS_CYCLES(MS)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .dual_channel_mode(dual_channel_mode), .cfg_apply(cfg_apply),
        .cfg_pkt_len(cfg_pkt_len), .cfg_dlm1(cfg_dlm1), .cfg_dlm2(cfg_dlm2),
        .cfg_match_one(cfg_match_one), .cfg_post(cfg_post), .cfg_force_ms(cfg_force_ms),
        .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready),
        .net_data(net_data), .net_last(net_last), .net_valid(net_valid),
        .net_ready(net_ready), .chan_active(chan_active));
    sdp_host_model i_host0 (.clk_sys(clk_sys), .ser_ready(ser_ready[0]),
        .ser_data(ser_data[7:0]), .ser_valid(ser_valid[0]));
    sdp_host_model i_host1 (.clk_sys(clk_sys), .ser_ready(ser_ready[1]),
        .ser_data(ser_data[15:8]), .ser_valid(ser_valid[1]));

    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // reference framing model
    // ----------------------------------------
    function automatic logic closes(int c, logic [7:0] b);
        logic [7:0] d1, d2;
        logic [10:0] len;
        logic m, hit;
        d1 = cfg_dlm1[c*8+:8];
        d2 = cfg_dlm2[c*8+:8];
        len = cfg_pkt_len[c*11+:11];
        m = 1'b0;
        cnt[c] = cnt[c] + 11'h001;
        if (pend[c] != 2'h0) begin
            pend[c] = pend[c] - 2'h1;
            m = (pend[c] == 2'h0);
        end else begin
            if (cfg_match_one[c] || d1 == 8'h00 || d2 == 8'h00)
                hit = (d1 != 8'h00 && b == d1) || (d2 != 8'h00 && b == d2);
            else
                hit = prev1[c] && b == d2;
            if (hit && d1 != 8'h00 && cfg_post[c*2+:2] != 2'h0) pend[c] = cfg_post[c*2+:2];
            else m = hit;
        end
        prev1[c] = (b == d1);
        m = m || (d1 == 8'h00 && d2 == 8'h00 && len == 11'h000);
        m = m || (len != 11'h000 && cnt[c] == len) || cnt[c] == 11'h400;
        if (m) begin
            cnt[c] = 11'h000;
            pend[c] = 2'h0;
            prev1[c] = 1'b0;
        end
        return m;
    endfunction

    task automatic cfg_ch(int c, int len, int d1, int d2, int one, int post, int fms);
        cfg_pkt_len[c*11+:11] = 11'(len);
        cfg_dlm1[c*8+:8] = 8'(d1);
        cfg_dlm2[c*8+:8] = 8'(d2);
        cfg_match_one[c] = one[0];
        cfg_post[c*2+:2] = 2'(post);
        cfg_force_ms[c*16+:16] = 16'(fms);
        cnt[c] = 11'h000;
        pend[c] = 2'h0;
        prev1[c] = 1'b0;
    endtask

    // wait until all expected words have left
    task automatic settle();
        while (exp_q[0].size() + exp_q[1].size() != 0) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic apply();
        cfg_apply = 1'b1;
        @(negedge clk_sys);
        cfg_apply = 1'b0;
        // ready is stale in the load cycle, a byte offered there is dropped
        @(negedge clk_sys);
    endtask

    // send n bytes, then keep going until a frame closes when tail is set
    task automatic feed(int c, int n, bit avoid, bit tail);
        logic [7:0] b;
        logic done;
        int i;
        i = 0;
        done = 1'b0;
        while (i < n || (tail && !done)) begin
            b = 8'h40 + 8'($urandom_range(31));
            if (!(avoid && i < n) && $urandom_range(3) == 0) b = 8'($urandom_range(3));
            done = closes(c, b);
            exp_q[c].push_back({done, b});
            if (c == 0) i_host0.send(b);
            else i_host1.send(b);
            if ($urandom_range(2) == 0) begin
                if (c == 0) i_host0.idle($urandom_range(3, 1));
                else i_host1.idle($urandom_range(3, 1));
            end
            i++;
        end
        if (!done) exp_q[c][$][8] = 1'b1;
        if (c == 0) i_host0.idle(tail ? 1 : 40);
        else i_host1.idle(tail ? 1 : 40);
    endtask

    // sink with random back-pressure and word compare
    always @(negedge clk_sys) begin
        for (int c = 0; c < 2; c++) begin
            net_ready[c] = !stall || $urandom_range(1) != 0;
            got = {net_last[c], net_data[c*8+:8]};
            if (net_valid[c] === 1'b1 && net_ready[c]) begin
                checks_done++;
                if (exp_q[c].size() == 0 || got !== exp_q[c][0]) begin
                    failures++;
                    $display("Error %0t ch%0d got %h exp %h", $time, c,
                        got, exp_q[c].size() ? exp_q[c][0] : 9'h000);
                end
                if (exp_q[c].size() != 0) void'(exp_q[c].pop_front());
            end
        end
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        {cfg_pkt_len, cfg_dlm1, cfg_dlm2, cfg_match_one, cfg_post, cfg_force_ms} = '0;
        void'($urandom(32'hC5813900));
        stall = 1'b0;
        reset = 1'b1;
        dual_channel_mode = 1'b1;
        cfg_apply = 1'b0;
        net_ready = 2'h0;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        for (int t = 0; t < 15; t++) begin
            settle();
            case (t)
                0: begin
                    cfg_ch(0, 0, 0, 0, 0, 0, 0);
                    cfg_ch(1, 1, 1, 2, 0, 0, 0);
                end
                1: begin
                    cfg_ch(0, 0, 1, 0, 1, 0, 0);
                    cfg_ch(1, 0, 1, 2, 0, 2, 0);
                end
                2: begin
                    cfg_ch(0, 0, 1, 2, 0, 1, 2);
                    cfg_ch(1, 0, 3, 0, 1, 0, 1);
                end
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        rlen = ($urandom_range(2) != 0) ? $urandom_range(24, 1) : 0;
                        cfg_ch(c, rlen, $urandom_range(2), $urandom_range(3), $urandom_range(1),
                            $urandom_range(2), 0);
                    end
                end
            endcase
            stall = (t > 2);
            apply();
            fork
                feed(0, t == 1 ? 1030 : 20, t < 3, t != 2);
                feed(1, 20, t < 3, t != 2);
            join
            $display("test %0d done, checks %0d", t, checks_done);
        end
        settle();
        dual_channel_mode = 1'b0;
        apply();
        repeat (3) @(negedge clk_sys);
        checks_done++;
        if (chan_active !== 2'b01 || ser_ready[1] !== 1'b0) begin
            failures++;
            $display("Error %0t active %h exp %h", $time, chan_active, 2'h1);
        end
        end_sim();
    end

    // watchdog at about ten times the expected run
    initial begin
        #2400000;
        failures++;
        end_sim();
    end
endmodule // testbench
